// *** common/nsio_pkg.sv ***
// Purpose: shared constants for the negative-sequence and instantaneous overcurrent block
// Assumes: 250 MHz system clock, phasor inputs from the current front end
// Notes: register map, field positions, reset values and timing counts
package nsio_pkg;
	localparam int CUR_W = 16;
	localparam int NS_W = 20;
	localparam int MAG_W = 40;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int ST_W = 4;
	localparam int CLK_HZ = 250_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	// least start blocking time, microseconds
	localparam int START_MIN_US = 30_000;
	localparam int START_MIN_CYC_DEF = START_MIN_US * CLK_PER_US;
	// fixed point sqrt(3) in Q14 and 1/6 in Q16
	localparam logic signed [35:0] SQ3_Q14 = 36'sh0_0000_6EDA;
	localparam int SQ3_SH = 14;
	localparam logic signed [35:0] DIV6_Q16 = 36'sh0_0000_2AAB;
	localparam int DIV6_SH = 16;
	// percent squared, to compare against squared magnitudes
	localparam logic [63:0] PCT_SQ = 64'h0000_0000_0000_2710;
	// register offsets
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_OC_PICK = 8'h04;
	localparam logic [AW-1:0] REG_OC_DLY = 8'h08;
	localparam logic [AW-1:0] REG_OC_CFG = 8'h0C;
	localparam logic [AW-1:0] REG_OC_RDLY = 8'h10;
	localparam logic [AW-1:0] REG_ADP_CFG = 8'h14;
	localparam logic [AW-1:0] REG_OC_TMIN = 8'h18;
	localparam logic [AW-1:0] REG_OC_IMAX = 8'h1C;
	localparam logic [AW-1:0] REG_FLC = 8'h20;
	localparam logic [AW-1:0] REG_IOC_PCT = 8'h24;
	localparam logic [AW-1:0] REG_IOC_START = 8'h28;
	localparam logic [AW-1:0] REG_IOC_DLY = 8'h2C;
	localparam logic [AW-1:0] REG_STAT = 8'h30;
	localparam logic [AW-1:0] REG_MASK = 8'h34;
	localparam logic [AW-1:0] REG_LIVE = 8'h38;
	// control fields
	localparam int CTRL_OC_EN = 0;
	localparam int CTRL_NSEQ = 1;
	localparam int CTRL_IOC_EN = 2;
	localparam int CTRL_ADP_EN = 3;
	// curve config fields
	localparam int CFG_MULT_LSB = 0;
	localparam int CFG_MULT_W = 8;
	localparam int CFG_INV = 8;
	localparam int CFG_RDEF = 9;
	localparam int DLY_W = 24;
	// status and live fields
	localparam int ST_OC_PICK = 0;
	localparam int ST_IOC_PICK = 1;
	localparam int ST_OC_TRIP = 2;
	localparam int ST_IOC_TRIP = 3;
	// reset values
	localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
	localparam logic [DW-1:0] CFG_RST = 32'h0000_0001;
	localparam logic [DW-1:0] ZERO_RST = 32'h0000_0000;
endpackage

// *** src/nsio_timer.sv ***
// Purpose: run timer that flags when a level has stood for a set count
// Assumes: run is a registered level
// Notes: count clears at once when run drops
`timescale 1ns/1ns
`default_nettype none
module nsio_timer #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic run,
	input wire logic [W-1:0] limit,
	// result
	output logic done
);
	logic [W-1:0] cnt_r;
	logic done_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst || !run)
		begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			if (cnt_r < limit)
				cnt_r <= cnt_r + 1'b1;
			done_r <= (cnt_r >= limit);
		end
	end

	assign done = done_r;
endmodule
`default_nettype wire

// *** src/nsio_top.sv ***
// Purpose: negative-sequence overcurrent and instantaneous overcurrent trip logic
// Assumes: phasor inputs synchronous to clk, updated by the current front end
// Notes: register port with read data one cycle after the read strobe
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module nsio_top #(
	parameter int START_MIN_CYC = nsio_pkg::START_MIN_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// phase current phasors
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph1_re,
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph1_im,
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph2_re,
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph2_im,
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph3_re,
	input wire logic signed [nsio_pkg::CUR_W-1:0] ph3_im,
	// plant status
	input wire logic undervolt_pick,
	input wire logic breaker_closed,
	// register port
	input wire logic [nsio_pkg::AW-1:0] addr,
	input wire logic [nsio_pkg::DW-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [nsio_pkg::DW-1:0] rdata,
	// protection outputs
	output logic trip_out,
	output logic oc_pickup,
	output logic ioc_pickup,
	output logic irq
);
	import nsio_pkg::*;

	logic [DW-1:0] ctrl_r, oc_pick_set_r, oc_dly_r, oc_cfg_r, oc_rdly_r, adp_cfg_r;
	logic [DW-1:0] oc_tmin_r, oc_imax_r, flc_r, ioc_pct_r, ioc_start_r, ioc_dly_r;
	logic [ST_W-1:0] stat_r, mask_r, live, ev_nxt, prev_r;
	logic [DW-1:0] rdata_r;
	logic irq_r, trip_r;
	logic signed [NS_W-1:0] nre_r, nim_r;
	logic [MAG_W-1:0] psq_r, nsq_r, meas_r, psq2_r;
	logic signed [35:0] t_re, t_im;
	logic [MAG_W-1:0] p1_sq, p2_sq, p3_sq, pmax;
	logic oc_pick_r, oc_trip_r, ioc_cmp_r, above_max_r;
	logic [DW-1:0] acc_r, rcnt_r, eff_delay, eff_cfg, start_lim;
	logic use_adp;
	logic [63:0] ioc_lhs, ioc_rhs, ioc_thr;
	logic start_done, ioc_done;

	function automatic logic [MAG_W-1:0] sq2(input logic signed [35:0] re, input logic signed [35:0] im);
		sq2 = MAG_W'(72'(re) * 72'(re) + 72'(im) * 72'(im));
	endfunction

	// register writes, stored as given, except the mask, which keeps only its low four bits
	// no range check
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_r <= CTRL_RST;
			oc_pick_set_r <= ZERO_RST;
			oc_dly_r <= ZERO_RST;
			oc_cfg_r <= CFG_RST;
			oc_rdly_r <= ZERO_RST;
			adp_cfg_r <= CFG_RST;
			oc_tmin_r <= ZERO_RST;
			oc_imax_r <= ZERO_RST;
			flc_r <= ZERO_RST;
			ioc_pct_r <= ZERO_RST;
			ioc_start_r <= ZERO_RST;
			ioc_dly_r <= ZERO_RST;
			mask_r <= '0;
		end
		else if (wr_stb)
		begin
			if (addr == REG_CTRL)
				ctrl_r <= wdata;
			else if (addr == REG_OC_PICK)
				oc_pick_set_r <= wdata;
			else if (addr == REG_OC_DLY)
				oc_dly_r <= wdata;
			else if (addr == REG_OC_CFG)
				oc_cfg_r <= wdata;
			else if (addr == REG_OC_RDLY)
				oc_rdly_r <= wdata;
			else if (addr == REG_ADP_CFG)
				adp_cfg_r <= wdata;
			else if (addr == REG_OC_TMIN)
				oc_tmin_r <= wdata;
			else if (addr == REG_OC_IMAX)
				oc_imax_r <= wdata;
			else if (addr == REG_FLC)
				flc_r <= wdata;
			else if (addr == REG_IOC_PCT)
				ioc_pct_r <= wdata;
			else if (addr == REG_IOC_START)
				ioc_start_r <= wdata;
			else if (addr == REG_IOC_DLY)
				ioc_dly_r <= wdata;
			else if (addr == REG_MASK)
				mask_r <= wdata[ST_W-1:0];
		end
	end

	assign live = {ioc_done, oc_trip_r, ioc_cmp_r, oc_pick_r};
	assign ev_nxt = live & ~prev_r;

	// sticky events, set wins over read clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stat_r <= '0;
			prev_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			prev_r <= live;
			if (rd_stb && addr == REG_STAT)
				stat_r <= ev_nxt;
			else
				stat_r <= stat_r | ev_nxt;
			irq_r <= |(stat_r & mask_r);
		end
	end

	// read data, one cycle after strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata_r <= '0;
		else if (!rd_stb)
			rdata_r <= '0;
		else if (addr == REG_CTRL)
			rdata_r <= ctrl_r;
		else if (addr == REG_OC_PICK)
			rdata_r <= oc_pick_set_r;
		else if (addr == REG_OC_DLY)
			rdata_r <= oc_dly_r;
		else if (addr == REG_OC_CFG)
			rdata_r <= oc_cfg_r;
		else if (addr == REG_OC_RDLY)
			rdata_r <= oc_rdly_r;
		else if (addr == REG_ADP_CFG)
			rdata_r <= adp_cfg_r;
		else if (addr == REG_OC_TMIN)
			rdata_r <= oc_tmin_r;
		else if (addr == REG_OC_IMAX)
			rdata_r <= oc_imax_r;
		else if (addr == REG_FLC)
			rdata_r <= flc_r;
		else if (addr == REG_IOC_PCT)
			rdata_r <= ioc_pct_r;
		else if (addr == REG_IOC_START)
			rdata_r <= ioc_start_r;
		else if (addr == REG_IOC_DLY)
			rdata_r <= ioc_dly_r;
		else if (addr == REG_STAT)
			rdata_r <= DW'(stat_r);
		else if (addr == REG_MASK)
			rdata_r <= DW'(mask_r);
		else if (addr == REG_LIVE)
			rdata_r <= DW'({start_done, live});
		else
			rdata_r <= '0;
	end

	// symmetrical component transform, scaled by 2 then divided by 6
	// negative sequence
	always_comb
	begin
		t_re = (36'(ph1_re) <<< 1) - 36'(ph2_re) - 36'(ph3_re)
			+ (((36'(ph2_im) - 36'(ph3_im)) * SQ3_Q14) >>> SQ3_SH);
		t_im = (36'(ph1_im) <<< 1) - 36'(ph2_im) - 36'(ph3_im)
			+ (((36'(ph3_re) - 36'(ph2_re)) * SQ3_Q14) >>> SQ3_SH);
	end

	assign p1_sq = sq2(36'(ph1_re), 36'(ph1_im));
	assign p2_sq = sq2(36'(ph2_re), 36'(ph2_im));
	assign p3_sq = sq2(36'(ph3_re), 36'(ph3_im));
	assign pmax = (p1_sq > p2_sq) ? ((p1_sq > p3_sq) ? p1_sq : p3_sq) : ((p2_sq > p3_sq) ? p2_sq : p3_sq);

	// measuring pipeline
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			nre_r <= '0;
			nim_r <= '0;
			psq_r <= '0;
			nsq_r <= '0;
			psq2_r <= '0;
			meas_r <= '0;
		end
		else
		begin
			nre_r <= NS_W'((t_re * DIV6_Q16) >>> DIV6_SH);
			nim_r <= NS_W'((t_im * DIV6_Q16) >>> DIV6_SH);
			psq_r <= pmax;
			nsq_r <= sq2(36'(nre_r), 36'(nim_r));
			psq2_r <= psq_r;
			meas_r <= ctrl_r[CTRL_NSEQ] ? nsq_r : psq2_r;
		end
	end

	assign use_adp = ctrl_r[CTRL_ADP_EN] && undervolt_pick;
	assign eff_cfg = use_adp ? adp_cfg_r : oc_cfg_r;

	// one curve path for both quantities
	always_comb
	begin
		eff_delay = DW'(oc_dly_r[DLY_W-1:0]) * DW'(eff_cfg[CFG_MULT_LSB +: CFG_MULT_W]);
		if (eff_cfg[CFG_INV] && above_max_r)
			eff_delay = oc_tmin_r;
	end

	// overcurrent pickup and timing
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			oc_pick_r <= 1'b0;
			above_max_r <= 1'b0;
			oc_trip_r <= 1'b0;
		end
		else
		begin
			oc_pick_r <= ctrl_r[CTRL_OC_EN]
				&& (meas_r > MAG_W'(oc_pick_set_r[CUR_W-1:0]) * MAG_W'(oc_pick_set_r[CUR_W-1:0]));
			above_max_r <= meas_r > MAG_W'(oc_imax_r[CUR_W-1:0]) * MAG_W'(oc_imax_r[CUR_W-1:0]);
			oc_trip_r <= oc_pick_r && ctrl_r[CTRL_OC_EN] && (acc_r >= eff_delay);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			acc_r <= '0;
			rcnt_r <= '0;
		end
		else if (oc_pick_r)
		begin
			rcnt_r <= '0;
			if (acc_r < eff_delay)
				acc_r <= acc_r + 1'b1;
		end
		else if (!eff_cfg[CFG_RDEF])
		begin
			acc_r <= '0;
			rcnt_r <= '0;
		end
		else if (rcnt_r >= oc_rdly_r)
		begin
			acc_r <= '0;
			rcnt_r <= '0;
		end
		else
			rcnt_r <= rcnt_r + 1'b1;
	end

	// instantaneous element, compared on squares
	// percent of full load
	always_comb
	begin
		ioc_thr = 64'(flc_r[CUR_W-1:0]) * 64'(ioc_pct_r[CUR_W-1:0]);
		ioc_rhs = ioc_thr * ioc_thr;
		ioc_lhs = 64'(psq_r) * PCT_SQ;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ioc_cmp_r <= 1'b0;
		else
			ioc_cmp_r <= ctrl_r[CTRL_IOC_EN] && (ioc_lhs > ioc_rhs);
	end

	assign start_lim = (ioc_start_r > DW'(START_MIN_CYC)) ? ioc_start_r : DW'(START_MIN_CYC);

	nsio_timer #(
		.W(DW)
	) u_start (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(breaker_closed),
		.limit(start_lim),
		.done(start_done)
	);

	nsio_timer #(
		.W(DW)
	) u_ioc_dly (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(ioc_cmp_r && start_done),
		.limit(ioc_dly_r),
		.done(ioc_done)
	);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			trip_r <= 1'b0;
		else
			trip_r <= oc_trip_r || ioc_done;
	end

	assign rdata = rdata_r;
	assign trip_out = trip_r;
	assign oc_pickup = oc_pick_r;
	assign ioc_pickup = ioc_cmp_r;
	assign irq = irq_r;

	nseq_select_a: assert property (@(posedge clk) disable iff (sys_rst)
		ctrl_r[CTRL_NSEQ] |=> meas_r == $past(nsq_r))
		else $error("measured quantity not negative sequence");
	nseq_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ph1_re == ph2_re && ph2_re == ph3_re && ph1_im == ph2_im && ph2_im == ph3_im)
		|=> (nre_r == '0 && nim_r == '0))
		else $error("zero sequence gave negative sequence");
	ioc_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ctrl_r[CTRL_IOC_EN] |=> !ioc_cmp_r)
		else $error("disabled instantaneous element picked up");
	ioc_fast_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ctrl_r[CTRL_IOC_EN] && ioc_lhs > ioc_rhs) |=> ioc_cmp_r)
		else $error("instantaneous pickup late");
	start_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		ioc_done |-> ($past(start_done) && start_lim >= DW'(START_MIN_CYC)))
		else $error("instantaneous trip during start block");
	inst_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!oc_pick_r && !eff_cfg[CFG_RDEF]) |=> acc_r == '0)
		else $error("timing state not cleared");
	tmin_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(eff_cfg[CFG_INV] && above_max_r) |-> eff_delay == oc_tmin_r)
		else $error("delay not held at minimum");
	adaptive_set_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ctrl_r[CTRL_ADP_EN] && undervolt_pick) |-> eff_cfg == adp_cfg_r)
		else $error("adaptive set not applied");
	oc_trip_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(oc_trip_r) |-> $past(oc_pick_r) && $past(acc_r) >= $past(eff_delay))
		else $error("trip before full delay");
	trip_out_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ioc_done || oc_trip_r) |=> trip_out)
		else $error("trip output missing");
endmodule
`default_nettype wire

// *** dv/nsio_ct_model.sv ***
// Purpose: plant model with three current transformers and the breaker trip circuit
// Assumes: amp is the phase magnitude, positive sequence rotation when balanced
// Notes: no current flows while the breaker is open; unbal leaves only phase 1
`timescale 1ns/1ns
`default_nettype none
module nsio_ct_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// plant control
	input wire logic close_cmd,
	input wire logic unbal,
	input wire logic [nsio_pkg::CUR_W-1:0] amp,
	input wire logic trip_out,
	// plant outputs
	output logic breaker_closed,
	output logic signed [nsio_pkg::CUR_W-1:0] ph1_re,
	output logic signed [nsio_pkg::CUR_W-1:0] ph1_im,
	output logic signed [nsio_pkg::CUR_W-1:0] ph2_re,
	output logic signed [nsio_pkg::CUR_W-1:0] ph2_im,
	output logic signed [nsio_pkg::CUR_W-1:0] ph3_re,
	output logic signed [nsio_pkg::CUR_W-1:0] ph3_im
);
	import nsio_pkg::*;
	logic tripped_r;
	logic [31:0] quad_w;
	logic signed [CUR_W-1:0] half;
	logic signed [CUR_W-1:0] quad;
	// trip coil holds the breaker open until the close command is withdrawn
	always_ff @(posedge clk)
	begin
		tripped_r <= !sys_rst && close_cmd && (tripped_r || trip_out);
		breaker_closed <= !sys_rst && close_cmd && !tripped_r && !trip_out;
	end
	// sin 120 degrees as 7094/8192
	assign quad_w = 32'(amp) * 32'h0000_1BB6;
	assign half = (breaker_closed && !unbal) ? signed'(amp >> 1) : '0;
	assign quad = (breaker_closed && !unbal) ? signed'(quad_w[28:13]) : '0;
	assign ph1_re = breaker_closed ? signed'(amp) : '0;
	assign ph1_im = '0;
	assign ph2_re = -half;
	assign ph2_im = -quad;
	assign ph3_re = -half;
	assign ph3_im = quad;
endmodule
`default_nettype wire

// *** dv/nsio_top_tb.sv ***
// Purpose: self-checking bench for the overcurrent block
// Assumes: start blocking minimum shortened to 20 cycles
// Notes: tests are register calls and current steps through the plant model
`timescale 1ns/1ns
`default_nettype none
module nsio_top_tb;
	import nsio_pkg::*;
	localparam int SMIN = 20;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic undervolt_pick = 1'b0;
	logic close_cmd = 1'b0;
	logic unbal = 1'b0;
	logic [CUR_W-1:0] amp = '0;
	logic breaker_closed;
	logic trip_out;
	logic oc_pickup;
	logic ioc_pickup;
	logic irq;
	logic [DW-1:0] rdata;
	logic signed [CUR_W-1:0] p1r, p1i, p2r, p2i, p3r, p3i;
	logic [DW-1:0] t_ctrl [5] = '{32'h1, 32'h3, 32'h3, 32'h3, 32'h1};
	logic [DW-1:0] t_pick [5] = '{32'h7D0, 32'h7D0, 32'h7D0, 32'hBB8, 32'h1F40};
	logic t_unb [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic t_exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	int n_fail = 0;
	int n_compared = 0;
	int n;
	always #2 clk = ~clk;
	nsio_ct_model nsio_ct_model_inst (.clk(clk), .sys_rst(sys_rst), .close_cmd(close_cmd), .unbal(unbal),
		.amp(amp), .trip_out(trip_out), .breaker_closed(breaker_closed), .ph1_re(p1r), .ph1_im(p1i),
		.ph2_re(p2r), .ph2_im(p2i), .ph3_re(p3r), .ph3_im(p3i));
	nsio_top #(.START_MIN_CYC(SMIN)) nsio_top_inst (.clk(clk), .sys_rst(sys_rst), .ph1_re(p1r), .ph1_im(p1i),
		.ph2_re(p2r), .ph2_im(p2i), .ph3_re(p3r), .ph3_im(p3i), .undervolt_pick(undervolt_pick),
		.breaker_closed(breaker_closed), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .trip_out(trip_out), .oc_pickup(oc_pickup), .ioc_pickup(ioc_pickup), .irq(irq));
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic close();
		@(posedge clk);
		close_cmd <= 1'b1;
	endtask
	task automatic reopen();
		@(posedge clk);
		close_cmd <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// cycles until trip, capped at lim
	task automatic trip_time(input int lim);
		n = 0;
		#1;
		while (trip_out !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic win(input int lo, input int hi);
		chk(DW'(n >= lo && n <= hi), 32'h1);
	endtask
	task automatic timed(input int lo, input int hi);
		close();
		trip_time(hi + 6);
		win(lo, hi);
		reopen();
	endtask
	// pickup drops for three cycles in mid-timing, then returns
	task automatic dropout(input logic [DW-1:0] cfg, input int lo, input int hi);
		wr(REG_OC_CFG, cfg);
		close();
		repeat (30) @(posedge clk);
		amp <= 16'h0000;
		repeat (3) @(posedge clk);
		amp <= 16'h2000;
		trip_time(80);
		win(lo, hi);
		reopen();
	endtask
	initial
	begin
		#40000;
		n_fail++;
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(REG_CTRL, CTRL_RST);
		rd(REG_OC_CFG, CFG_RST);
		rd(REG_ADP_CFG, CFG_RST);
		rd(REG_IOC_DLY, ZERO_RST);
		rd(8'h3C, ZERO_RST);
		wr(REG_OC_IMAX, 32'h0000_FFFF);
		rd(REG_OC_IMAX, 32'h0000_FFFF);
		$display("test registers done");
		amp <= 16'h2000;
		wr(REG_OC_PICK, 32'h0000_07D0);
		wr(REG_OC_DLY, 32'h0000_03E8);
		wr(REG_CTRL, 32'h0000_0001);
		close();
		repeat (8) @(posedge clk);
		#1;
		chk(DW'({irq, oc_pickup}), 32'h1);
		rd(REG_LIVE, 32'h0000_0001);
		reopen();
		wr(REG_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		chk(DW'(irq), 32'h1);
		rd(REG_STAT, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		chk(DW'(irq), 32'h0);
		rd(REG_MASK, 32'h0000_0001);
		$display("test interrupt done");
		for (int i = 0; i < 5; i++)
		begin
			wr(REG_CTRL, t_ctrl[i]);
			wr(REG_OC_PICK, t_pick[i]);
			unbal <= t_unb[i];
			close();
			repeat (8) @(posedge clk);
			#1;
			chk(DW'(oc_pickup), DW'(t_exp[i]));
			reopen();
		end
		$display("test measured quantity done");
		unbal <= 1'b1;
		wr(REG_CTRL, 32'h0000_0003);
		wr(REG_OC_PICK, 32'h0000_07D0);
		wr(REG_OC_DLY, 32'h0000_0028);
		for (int m = 1; m < 3; m++)
		begin
			wr(REG_OC_CFG, DW'(m));
			timed(40 * m, 40 * m + 14);
		end
		wr(REG_OC_RDLY, 32'h0000_000A);
		dropout(32'h0000_0201, 10, 24);
		dropout(CFG_RST, 40, 54);
		wr(REG_ADP_CFG, 32'h0000_0003);
		wr(REG_CTRL, 32'h0000_000B);
		undervolt_pick <= 1'b1;
		timed(120, 134);
		undervolt_pick <= 1'b0;
		wr(REG_CTRL, 32'h0000_0003);
		wr(REG_OC_CFG, 32'h0000_0101);
		wr(REG_OC_TMIN, 32'h0000_000A);
		wr(REG_OC_IMAX, 32'h0000_03E8);
		timed(10, 24);
		$display("test overcurrent timing done");
		unbal <= 1'b0;
		wr(REG_CTRL, ZERO_RST);
		wr(REG_FLC, 32'h0000_0064);
		wr(REG_IOC_PCT, 32'h0000_04B0);
		close();
		trip_time(60);
		chk(DW'({trip_out, ioc_pickup}), ZERO_RST);
		reopen();
		wr(REG_CTRL, 32'h0000_0004);
		amp <= 16'h03E8;
		close();
		trip_time(60);
		chk(DW'({trip_out, ioc_pickup}), ZERO_RST);
		reopen();
		amp <= 16'h2000;
		close();
		repeat (5) @(posedge clk);
		#1;
		chk(DW'({trip_out, ioc_pickup}), 32'h1);
		trip_time(40);
		win(SMIN - 5, SMIN + 8);
		repeat (8) @(posedge clk);
		#1;
		chk(DW'(ioc_pickup), ZERO_RST);
		reopen();
		wr(REG_IOC_DLY, 32'h0000_0028);
		timed(40, SMIN + 54);
		wr(REG_IOC_DLY, ZERO_RST);
		wr(REG_IOC_START, 32'h0000_0028);
		timed(40, 54);
		$display("test instantaneous done");
		report_and_stop();
	end
endmodule
`default_nettype wire
